// file: bench/tdc_channel_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module tdc_channel_asserts(
	// clock
	input wire logic ref_clk,
	input wire logic reset,
	// watched
	input wire logic timerUnitEnable,
	input wire logic startTrigger,
	input wire logic stopTrigger,
	input wire logic [15:0] channelDownCount,
	input wire logic channelEnabledStatus,
	input wire logic channelDoneIrq,
	input wire logic channelStatusReg
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	wire logic u = timerUnitEnable;
	wire logic e = channelEnabledStatus;
	wire logic q = channelDoneIrq;
	wire logic [15:0] c = channelDownCount;
	start_en_a: assert property (u && startTrigger && !stopTrigger |=> !u || e)
		else $error("start");
	stop_en_a: assert property (u && stopTrigger |=> !u || !e)
		else $error("stop");
	stop_hold_a: assert property (u && !e |=> !u || $stable(c))
		else $error("hold");
	irq_pulse_a: assert property (q |=> !q)
		else $error("pulse");
	irq_zero_a: assert property (q |-> c == 16'h0000 && e)
		else $error("irq");
	unit_off_a: assert property (!u |=> c == 16'h0000 && !e && !q)
		else $error("off");
	step_one_a: assert property (u && $past(u) && c < $past(c) |-> c == $past(c) - 16'h0001)
		else $error("step");
	status_idle_a: assert property (channelStatusReg == 1'b0)
		else $error("status");
	cover property (q);
	cover property (u && stopTrigger && c != 16'h0000);
	cover property (!u ##1 u);
endmodule
`default_nettype wire

// file: bench/tdc_edge_source.sv
`timescale 1ns/1ps
`default_nettype none
module tdc_edge_source(
	// clock and request
	input wire logic ref_clk,
	input wire logic fire,
	// pin
	output logic pin
);
	logic [3:0] hold = 4'h0;
	// held past sync and filter so no edge is lost
	always @(posedge ref_clk)
		hold <= fire ? 4'h9 : hold - {3'h0, hold != 4'h0};
	assign pin = hold != 4'h0;
endmodule
`default_nettype wire

// file: bench/test_timer_delay_counter_channel.sv
`timescale 1ns/1ps
`default_nettype none
`include "tdc_map.svh"
module test_timer_delay_counter_channel;
	logic ref_clk, reset, en, wr, st, sp, fire, pin, oe, out, irq, ena, stat;
	logic [15:0] cnt;
	tdc_pkg::tdc_ctrl_t ctrl;
	int errors = 0, comparisons = 0, i, k, d;
	tdc_channel dut(.ref_clk, .reset, .timerUnitEnable(en), .writeStrobe(wr), .ctrlIn(ctrl),
		.startTrigger(st), .stopTrigger(sp), .channelTimerInput(pin), .channelTimerOutput(out),
		.channelTimerOutputEnable(oe), .channelDownCount(cnt), .channelEnabledStatus(ena),
		.channelDoneIrq(irq), .prescaledClockTicks(), .channelStatusReg(stat));
	tdc_edge_source src(.ref_clk, .fire, .pin);
	initial
	begin
		ref_clk = 0;
		forever #25 ref_clk = ~ref_clk;
	end
	task automatic step(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			errors++;
			$display("[ERR] %0t got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic pulse(ref logic s);
		s = 1;
		step(1);
		s = 0;
	endtask
	task automatic setup(input int v);
		ctrl = '{1'b1, 16'h0000, i[0], `TDC_MODE_DELAY, v[15:0], 1'b0, 2'h0};
		pulse(wr);
	endtask
	// irq lands one tick after the count hits zero
	function automatic int lag(int v);
		return v + 1;
	endfunction
	task automatic summarize;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial
	begin
		#100us;
		errors++;
		summarize;
	end
	initial
	begin
		{reset, en, wr, st, sp, fire} = 6'h20;
		ctrl = '0;
		void'($urandom(40541));
		step(10);
		reset = 0;
		en = 1;
		for (i = 0; i < 4; i++)
		begin
			d = 2 + $urandom % 30;
			setup(d);
			pulse(st);
			check(ena, 1'b1);
			pulse(fire);
			for (k = 0; k < 20 && cnt === 16'h0000; k++)
				step(1);
			check(cnt, d[15:0]);
			setup(d + 40);
			for (k = 1; k < 200 && irq !== 1'b1; k++)
				step(1);
			check(k[15:0], 16'(lag(d)));
			step(3);
			check(cnt, 16'h0000);
			$display("test %0d done", i);
		end
		pulse(fire);
		step(10);
		pulse(sp);
		check(ena, 1'b0);
		k = cnt;
		pulse(fire);
		step(12);
		check(cnt, k[15:0]);
		check(irq, 1'b0);
		en = 0;
		step(2);
		check(cnt, 16'h0000);
		en = 1;
		pulse(fire);
		step(12);
		check({cnt[15:1], ena}, 16'h0000);
		summarize;
	end
endmodule
bind tdc_channel tdc_channel_asserts chk(.ref_clk, .reset, .timerUnitEnable, .startTrigger,
	.stopTrigger, .channelDownCount, .channelEnabledStatus, .channelDoneIrq, .channelStatusReg);
`default_nettype wire

// file: hw/tdc_channel.sv
// Contract
// - unit disabled: no clock, writes ignored
// - enable starts clock, channels stopped
// - clock select sets four prescaled clocks
// - input noise filter switchable per input
// - start trigger sets enabled, self-clears
// - after start, wait for valid edge
// - valid edge loads delay into count
// - count down, interrupt at zero, hold
// - delay rewritable without disturbing count
// - count readable at any time
// - status register meaningless in this mode
// - stop trigger clears enabled, keeps count
// - restart from stop without re-setup
// - unit disable initializes all channel state
// - eight channels per unit, two units
`timescale 1ns/1ps
`default_nettype none
`include "tdc_map.svh"
module tdc_channel #(
	parameter int UNIT_INDEX = 0,
	parameter int CHANNEL_INDEX = 0
)(
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// software control
	input wire logic timerUnitEnable,
	input wire logic writeStrobe,
	input wire tdc_pkg::tdc_ctrl_t ctrlIn,
	input wire logic startTrigger,
	input wire logic stopTrigger,
	// pins
	input wire logic channelTimerInput,
	output logic channelTimerOutput,
	output logic channelTimerOutputEnable,
	// status
	output logic [15:0] channelDownCount,
	output logic channelEnabledStatus,
	output logic channelDoneIrq,
	output logic [3:0] prescaledClockTicks,
	output logic channelStatusReg
);
	// refuse an index outside the two units of eight channels
	if (UNIT_INDEX < 0 || UNIT_INDEX > 1 || CHANNEL_INDEX < 0 || CHANNEL_INDEX > 7)
	begin : gBadIndex
		$error("unit 0..1, channel 0..7 only");
	end

	tdc_pkg::tdc_state_reg_t r;
	tdc_pkg::tdc_state_reg_t next_r;
	logic rawEdge;
	logic filtEdge;
	logic validEdge;
	logic opTick;
	logic [3:0] fieldHit;

	// each prescaled clock divides by 2^field of the clock select word
	genvar g;
	generate
		for (g = 0; g < 4; g++)
		begin : gPre
			always_comb
			begin
				fieldHit[g] = (r.prescaleCount & ((16'h0001 << r.unitClockSelect[g*4 +: 4])
					- 16'h0001)) == 16'h0000;
			end
		end
	endgenerate

	always_comb
	begin
		next_r = r;
		rawEdge = 1'b0;
		filtEdge = 1'b0;
		next_r.channelDoneIrq = 1'b0;
		next_r.tick = 4'h0;
		next_r.inSync = {r.inSync[1:0], channelTimerInput};
		// change counts once the 2nd and 3rd stage agree
		if (r.inSync[2] == r.inSync[1])
		begin
			rawEdge = r.inSync[1] & ~r.inLevel;
			next_r.inLevel = r.inSync[1];
		end
		// filter: level must stand for extra samples before it counts
		next_r.filt = (r.inSync[1] == r.inLevel) ? 2'h0 :
			((r.filt == `TDC_FILTER_TAPS) ? r.filt : r.filt + 2'h1);
		filtEdge = rawEdge && (r.filt == `TDC_FILTER_TAPS);
		validEdge = r.noiseFilterEnable ? filtEdge : rawEdge;
		if (r.noiseFilterEnable && !(r.filt == `TDC_FILTER_TAPS) && rawEdge)
			next_r.inLevel = r.inLevel; // hold off until filter settles
		if (r.noiseFilterEnable && filtEdge)
			next_r.inLevel = 1'b1;

		// prescaler runs only while the unit has its clock
		next_r.prescaleCount = r.prescaleCount + 16'h0001;
		next_r.tick = fieldHit;
		opTick = r.tick[r.prescaleSel];

		if (writeStrobe)
		begin
			next_r.unitClockSelect = ctrlIn.unitClockSelect;
			next_r.noiseFilterEnable = ctrlIn.noiseFilterEnable;
			next_r.channelModeReg = ctrlIn.channelModeReg;
			next_r.channelDelayValue = ctrlIn.channelDelayValue;
			next_r.channelOutputEnable = ctrlIn.channelOutputEnable;
			next_r.prescaleSel = ctrlIn.prescaleSel;
		end

		case (r.state)
			tdc_pkg::ST_STOPPED:
			begin
				// input edges fall through here unused
				if (startTrigger)
				begin
					next_r.state = tdc_pkg::ST_WAIT_EDGE;
					next_r.channelEnabledStatus = 1'b1;
				end
			end
			tdc_pkg::ST_WAIT_EDGE, tdc_pkg::ST_HOLD_ZERO:
			begin
				if (validEdge)
				begin
					next_r.channelDownCount = r.channelDelayValue;
					next_r.state = tdc_pkg::ST_COUNTING;
				end
			end
			tdc_pkg::ST_COUNTING:
			begin
				if (validEdge)
					next_r.channelDownCount = r.channelDelayValue;
				else if (opTick)
				begin
					if (r.channelDownCount == `TDC_COUNT_ZERO)
					begin
						next_r.channelDoneIrq = 1'b1;
						next_r.state = tdc_pkg::ST_HOLD_ZERO;
					end
					else
					begin
						next_r.channelDownCount = r.channelDownCount - 16'h0001;
					end
				end
			end
			default:
			begin
				next_r.state = tdc_pkg::ST_STOPPED;
			end
		endcase

		// stop acts only outside stopped, so start wins while stopped; count is held
		if (stopTrigger && r.state != tdc_pkg::ST_STOPPED)
		begin
			next_r.state = tdc_pkg::ST_STOPPED;
			next_r.channelEnabledStatus = 1'b0;
			next_r.channelDownCount = r.channelDownCount;
			next_r.channelDoneIrq = 1'b0;
		end
		next_r.channelTimerOutput = 1'b0;
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset || !timerUnitEnable)
		begin
			r <= '{state: tdc_pkg::ST_STOPPED, channelModeReg: `TDC_MODE_RESET,
				channelDelayValue: `TDC_DATA_RESET, unitClockSelect: `TDC_CLKSEL_RESET,
				default: '0};
		end
		else
		begin
			r <= next_r;
		end
	end

	assign channelTimerOutput = r.channelTimerOutput;
	assign channelTimerOutputEnable = r.channelOutputEnable; // software keeps 0 here
	assign channelDownCount = r.channelDownCount;
	assign channelEnabledStatus = r.channelEnabledStatus;
	assign channelDoneIrq = r.channelDoneIrq;
	assign prescaledClockTicks = r.tick;
	assign channelStatusReg = 1'b0;
endmodule
`default_nettype wire

// file: hw/tdc_map.svh
`ifndef TDC_MAP_SVH
`define TDC_MAP_SVH
`define TDC_COUNT_ZERO 16'h0000
`define TDC_DATA_RESET 16'h0000
`define TDC_MODE_DELAY 4'h4
`define TDC_MODE_RESET 4'h0
`define TDC_CLKSEL_RESET 16'h0000
`define TDC_FILTER_TAPS 2'h2
`endif

// file: hw/tdc_pkg.sv
package tdc_pkg;
	typedef enum logic [1:0] {
		ST_STOPPED,
		ST_WAIT_EDGE,
		ST_COUNTING,
		ST_HOLD_ZERO
	} tdc_state_t;

	typedef struct packed {
		logic unitEnable;
		logic [15:0] unitClockSelect;
		logic noiseFilterEnable;
		logic [3:0] channelModeReg;
		logic [15:0] channelDelayValue;
		logic channelOutputEnable;
		logic [1:0] prescaleSel;
	} tdc_ctrl_t;

	typedef struct packed {
		logic [2:0] inSync;
		logic [1:0] filt;
		logic inLevel;
		logic [3:0] tick;
		logic [15:0] prescaleCount;
		tdc_state_t state;
		logic [15:0] channelDownCount;
		logic channelEnabledStatus;
		logic channelDoneIrq;
		logic channelTimerOutput;
		logic [3:0] channelModeReg;
		logic [15:0] channelDelayValue;
		logic [15:0] unitClockSelect;
		logic noiseFilterEnable;
		logic channelOutputEnable;
		logic [1:0] prescaleSel;
	} tdc_state_reg_t;
endpackage
